// ---- wcf_map.svh ----
/*
 * Constants for the write-frame checksum pair: register offsets,
 * field positions, frame lengths and alert timing.
 * Assumes a 200 MHz core clock; included by the package and both ends.
 */
`ifndef WCF_MAP_SVH
`define WCF_MAP_SVH

// ****************************************************************
// checksum and frame shape
// ****************************************************************
`define WCF_POLY          8'h07
`define WCF_LAST_DATA     4'd7
`define WCF_LAST_CRC      4'd9
`define WCF_BEAT_CRC_A    4'd8

// ****************************************************************
// alert timing
// ****************************************************************
`define WCF_CLK_NS        5
`define WCF_ALERT_LAT_NS  13
`define WCF_ALERT_LAT_CYC (`WCF_ALERT_LAT_NS / `WCF_CLK_NS)
`define WCF_ALERT_PW      3'd6
`define WCF_LISTEN_CYC    4'((`WCF_ALERT_LAT_CYC) + 6)
`define WCF_MAX_RETRY     2'd2

// ****************************************************************
// controller register word offsets (byte address bits 4:2)
// ****************************************************************
`define WCF_REG_CTRL      3'h0
`define WCF_REG_DATA0     3'h1
`define WCF_REG_DATA4     3'h5
`define WCF_REG_CMD       3'h6
`define WCF_REG_STATUS    3'h7
`define WCF_CTRL_CRC_EN   2
`define WCF_CTRL_DM_EN    3
`define WCF_CTRL_DBI_EN   4
`define WCF_CTRL_INJECT   5
`define WCF_CMD_GO        0
`define WCF_ST_BUSY       0
`define WCF_ST_ERR        1
`define WCF_ST_FAIL       2

`endif

// ---- wcf_pkg.sv ----
/*
 * Types and shared functions of the write-frame checksum pair:
 * organisation, controller states, the 72-input checksum tree,
 * unused-input filling and lane-to-tree mapping.
 * Assumes wcf_map.svh is on the include path.
 */
`include "wcf_map.svh"

package wcf_pkg;

	typedef enum logic [1:0] {
		WCF_X4  = 2'b00,
		WCF_X8  = 2'b01,
		WCF_X16 = 2'b10
	} wcf_width_t;

	// gray along idle -> send -> listen
	typedef enum logic [1:0] {
		WCF_IDLE   = 2'b00,
		WCF_SEND   = 2'b01,
		WCF_LISTEN = 2'b11
	} wcf_hstate_t;

	typedef logic [143:0] wcf_tree_t;

	// serial form of the tree, bit 71 shifted first from zero;
	// unrolled by synthesis into the fixed xor network
	function automatic logic [7:0] checksum_next_72in(input logic [71:0] d);
		logic [7:0] c;
		logic       fb;
		c = 8'h00;
		for (int i = 71; i >= 0; i--)
		begin
			fb = c[7] ^ d[i];
			c  = {c[6:0], 1'b0} ^ ({8{fb}} & `WCF_POLY);
		end
		return c;
	endfunction : checksum_next_72in

	// forces unused tree inputs to one for the organisation
	function automatic wcf_tree_t tree_fill(input wcf_width_t w,
		input logic side_on, input wcf_tree_t raw);
		wcf_tree_t t;
		t = raw;
		if (!side_on)
		begin
			t[71:64]   = 8'hff;
			t[143:136] = 8'hff;
		end
		if (w == WCF_X4)
			t[143:32] = {112{1'b1}};
		else if (w == WCF_X8)
			t[143:72] = {72{1'b1}};
		return t;
	endfunction : tree_fill

	// tree lane of data pin n: lower byte, lower mask, upper byte
	function automatic int lane_of(input int n);
		return (n < 8) ? n : n + 1;
	endfunction : lane_of

endpackage : wcf_pkg

// ---- wcf_link_if.sv ----
/*
 * Write-data link between controller and device: one transfer per
 * clock while wr_valid is high, plus the shared open-drain alert.
 * Assumes both ends run on the same clock; pull-up modelled here.
 */
`timescale 1ns/1ps

interface wcf_link_if;
	logic        wr_valid;
	logic [15:0] dq;
	logic [1:0]  dmi;
	logic        alert_o;
	logic        alert_oe;
	wire         alert_n;

	// open drain: released line reads high
	assign alert_n = alert_oe ? alert_o : 1'b1;

	modport host (output wr_valid, output dq, output dmi, input alert_n);
	modport dev  (input wr_valid, input dq, input dmi,
		output alert_o, output alert_oe);
endinterface : wcf_link_if

// ---- wcf_host.sv ----
/*
 * Controller end: builds checksum-protected write frames from
 * registers reached over Avalon-MM, and retries on alert.
 * Assumes the device shares clk and the bus master holds requests.
 */
// Chosen here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`include "wcf_map.svh"

module wcf_host (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	wcf_link_if.host         link
);
	import wcf_pkg::*;

	logic [5:0]        ctrl_q;
	wcf_tree_t         data_q;
	wcf_hstate_t       state_q;
	logic [3:0]        beat_q;
	logic [3:0]        win_q;
	logic [1:0]        retry_q;
	logic              inj_q;
	logic              err_q;
	logic              fail_q;
	logic              wait_q;
	logic [31:0]       rdata_q;
	logic              valid_q;
	logic [15:0]       dq_q;
	logic [1:0]        dmi_q;
	logic              alert_prev_q;
	logic [15:0]       beat_dq;
	logic [1:0]        beat_dmi;

	// ****************************************************************
	// decode
	// ****************************************************************
	wire         req       = avs_read | avs_write;
	wire         done      = req & ~wait_q;
	wire         wr_hit    = avs_write & done;
	wire [2:0]   sel       = avs_address[4:2];
	wire         idle      = (state_q == WCF_IDLE);
	wcf_width_t  width;
	assign width = wcf_width_t'(ctrl_q[1:0]);
	wire         crc_en    = ctrl_q[`WCF_CTRL_CRC_EN];
	wire         dm_en     = ctrl_q[`WCF_CTRL_DM_EN];
	wire         dbi_en    = ctrl_q[`WCF_CTRL_DBI_EN] & ~dm_en;
	wire         side_on   = dm_en | dbi_en;
	wire         go        = wr_hit & (sel == `WCF_REG_CMD)
		& avs_writedata[`WCF_CMD_GO] & idle;
	wire         alert_fall = alert_prev_q & ~link.alert_n;
	wire [3:0]   last_beat = crc_en ? `WCF_LAST_CRC : `WCF_LAST_DATA;
	wire wcf_tree_t tree   = tree_fill(width, side_on, data_q);
	wire [7:0]   crc_lo    = checksum_next_72in(tree[71:0])
		^ {7'h00, inj_q};
	wire [7:0]   crc_hi    = checksum_next_72in(tree[143:72]);

	// ****************************************************************
	// frame beat builder
	// ****************************************************************
	// frame assembly
	always_comb
	begin
		for (int n = 0; n < 16; n++)
		begin
			if (beat_q <= `WCF_LAST_DATA)
				beat_dq[n] = tree[8 * lane_of(n) + int'(beat_q)];
			else if (beat_q == `WCF_BEAT_CRC_A)
				beat_dq[n] = (n < 8) ? crc_lo[n] : crc_hi[n - 8];
			else
				// ones in transfer 9; x4 upper checksum half
				beat_dq[n] = (width == WCF_X4 && n < 4) ? crc_lo[n + 4]
					: 1'b1;
		end
		beat_dmi[0] = (beat_q <= `WCF_LAST_DATA)
			? tree[64 + int'(beat_q)] : 1'b1;
		beat_dmi[1] = (beat_q <= `WCF_LAST_DATA)
			? tree[136 + int'(beat_q)] : 1'b1;
	end

	// read mux
	logic [31:0] rd_mux;
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		unique case (sel)
			`WCF_REG_CTRL:   rd_mux = {26'h0, ctrl_q};
			3'h1:            rd_mux = data_q[31:0];
			3'h2:            rd_mux = data_q[63:32];
			3'h3:            rd_mux = data_q[95:64];
			3'h4:            rd_mux = data_q[127:96];
			`WCF_REG_DATA4:  rd_mux = {16'h0, data_q[143:128]};
			`WCF_REG_CMD:    rd_mux = 32'h0000_0000;
			`WCF_REG_STATUS: rd_mux = {26'h0, retry_q, 1'b0, fail_q,
				err_q, ~idle};
		endcase
	end

	// ****************************************************************
	// bus slave: one wait cycle, write lands when waitrequest is low
	// ****************************************************************
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			wait_q <= ~(req & wait_q);
			if (req & wait_q)
				rdata_q <= rd_mux;
		end
	end

	// configuration and data; frozen while a frame is in flight so a
	// retry resends exactly what failed
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_q <= 6'h00;
			data_q <= '0;
		end
		else if (wr_hit & idle)
		begin
			if (sel == `WCF_REG_CTRL)
				ctrl_q <= avs_writedata[5:0];
			else if (sel == 3'h1)
				data_q[31:0] <= avs_writedata;
			else if (sel == 3'h2)
				data_q[63:32] <= avs_writedata;
			else if (sel == 3'h3)
				data_q[95:64] <= avs_writedata;
			else if (sel == 3'h4)
				data_q[127:96] <= avs_writedata;
			else if (sel == `WCF_REG_DATA4)
				data_q[143:128] <= avs_writedata[15:0];
		end
	end

	// sticky flags: hardware set wins over write-one clear
	wire st_wr = wr_hit & (sel == `WCF_REG_STATUS);
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			err_q        <= 1'b0;
			alert_prev_q <= 1'b1;
		end
		else
		begin
			alert_prev_q <= link.alert_n;
			err_q <= alert_fall
				| (err_q & ~(st_wr & avs_writedata[`WCF_ST_ERR]));
		end
	end

	// ****************************************************************
	// frame sequencer
	// ****************************************************************
	wire retry_left = (retry_q != `WCF_MAX_RETRY);
	wire give_up    = (state_q == WCF_LISTEN) & alert_fall & ~retry_left;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			fail_q <= 1'b0;
		else
			fail_q <= give_up
				| (fail_q & ~(st_wr & avs_writedata[`WCF_ST_FAIL]));
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_q <= WCF_IDLE;
			beat_q  <= 4'd0;
			win_q   <= 4'd0;
			retry_q <= 2'd0;
			inj_q   <= 1'b0;
			valid_q <= 1'b0;
			dq_q    <= 16'hffff;
			dmi_q   <= 2'b11;
		end
		else
		begin
			valid_q <= (state_q == WCF_SEND);
			dq_q    <= (state_q == WCF_SEND) ? beat_dq : 16'hffff;
			dmi_q   <= (state_q == WCF_SEND) ? beat_dmi : 2'b11;
			unique case (state_q)
				WCF_IDLE:
					if (go)
					begin
						state_q <= WCF_SEND;
						beat_q  <= 4'd0;
						retry_q <= 2'd0;
						inj_q   <= ctrl_q[`WCF_CTRL_INJECT];
					end
				WCF_SEND:
					if (beat_q == last_beat)
					begin
						state_q <= crc_en ? WCF_LISTEN : WCF_IDLE;
						win_q   <= `WCF_LISTEN_CYC;
					end
					else
						beat_q <= beat_q + 4'd1;
				WCF_LISTEN:
					if (alert_fall & retry_left)
					begin
						state_q <= WCF_SEND;
						beat_q  <= 4'd0;
						retry_q <= retry_q + 2'd1;
						inj_q   <= 1'b0;
					end
					else if (alert_fall | (win_q == 4'd0))
						state_q <= WCF_IDLE;
					else
						win_q <= win_q - 4'd1;
			endcase
		end
	end

	assign avs_waitrequest = wait_q;
	assign avs_readdata    = rdata_q;
	assign link.wr_valid   = valid_q;
	assign link.dq         = dq_q;
	assign link.dmi        = dmi_q;

endmodule : wcf_host

// ---- wcf_dev.sv ----
/*
 * Device end: receives write frames, commits data early, recomputes
 * the checksum and reports mismatches by an alert pulse and flags.
 * Assumes the controller shares clk and sends beats back to back.
 */
//Contract
//- eight-bit checksum, x8+x2+x+1, 72 inputs
//- bit 71 first, zero start state
//- controller builds checksum and frame layout
//- device recomputes, compares, reports any mismatch
//- full writes commit before check completes
//- controller resends failed write coherently
//- x4: 32 inputs, 32..71 forced one
//- x4 lane n: data, bit n, n+4
//- x8 controller sends ones in transfer 9
//- x8 inputs 64..71 sideband or ones
//- inversion and masking never both enabled
//- x8 lane mapping, sideband ones after data
//- x16 controller ones in transfer 9
//- x16 two trees, halves 71:0, 143:72
//- x16 sideband inputs ones when both off
//- x16 upper lanes carry 72..143, bits 8..15
//- checksum frames last ten transfers
//- mismatch gives alert low pulse, six clocks
//- mismatch sets flags until controller clears
`timescale 1ns/1ps
`include "wcf_map.svh"

module wcf_dev (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire wcf_pkg::wcf_width_t  cfg_width,
	input  wire logic                 crc_en,
	input  wire logic                 dm_en,
	input  wire logic                 dbi_en,
	input  wire logic                 err_clr,
	wcf_link_if.dev                   link,
	output logic      [143:0]         wr_data,
	output logic                      wr_commit,
	output logic                      crc_err,
	output logic                      err_clear_bit,
	output logic                      err_status_bit
);
	import wcf_pkg::*;

	logic [3:0]   beat_q;
	wcf_tree_t    rx_q;
	wcf_tree_t    rx_d;
	logic [15:0]  crc_rx_q;
	logic         chk_q;
	logic [2:0]   alert_cnt_q;
	logic         alert_oe_q;
	wcf_tree_t    wr_data_q;
	logic         wr_commit_q;
	logic         crc_err_q;
	logic         err_clear_q;
	logic         err_status_q;

	// ****************************************************************
	// decode
	// ****************************************************************
	wire        side_on   = dm_en | dbi_en;
	wire [3:0]  last_beat = crc_en ? `WCF_LAST_CRC : `WCF_LAST_DATA;
	wire        in_data   = link.wr_valid & (beat_q <= `WCF_LAST_DATA);
	wire        end_data  = link.wr_valid & (beat_q == `WCF_LAST_DATA);
	wire wcf_tree_t rx_full = tree_fill(cfg_width, side_on, rx_q);
	wire [7:0]  calc_lo   = checksum_next_72in(rx_full[71:0]);
	wire [7:0]  calc_hi   = checksum_next_72in(rx_full[143:72]);
	wire        mismatch  = (calc_lo != crc_rx_q[7:0])
		| ((cfg_width == WCF_X16) & (calc_hi != crc_rx_q[15:8]));
	wire        bad       = chk_q & mismatch;

	// ****************************************************************
	// receive path
	// ****************************************************************
	// lanes to tree inputs
	always_comb
	begin
		rx_d = rx_q;
		if (in_data)
		begin
			for (int n = 0; n < 16; n++)
				rx_d[8 * lane_of(n) + int'(beat_q)] = link.dq[n];
			rx_d[64 + int'(beat_q)]  = link.dmi[0];
			rx_d[136 + int'(beat_q)] = link.dmi[1];
		end
	end

	// beat counter wraps to zero after each frame's last valid transfer
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			beat_q <= 4'd0;
		else if (link.wr_valid)
			beat_q <= (beat_q == last_beat) ? 4'd0 : beat_q + 4'd1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rx_q     <= '0;
			crc_rx_q <= 16'h0000;
			chk_q    <= 1'b0;
		end
		else
		begin
			rx_q <= rx_d;
			// x4 checksum split over transfers 8, 9
			if (link.wr_valid & (beat_q == `WCF_BEAT_CRC_A))
				crc_rx_q <= link.dq;
			if (link.wr_valid & (beat_q == `WCF_LAST_CRC)
				& (cfg_width == WCF_X4))
				crc_rx_q[7:4] <= link.dq[3:0];
			chk_q <= link.wr_valid & (beat_q == `WCF_LAST_CRC) & crc_en;
		end
	end

	// ****************************************************************
	// early commit: data leaves before the checksum is known, so a
	// bad write lands in the array and must be overwritten by a retry
	// ****************************************************************
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wr_data_q   <= '0;
			wr_commit_q <= 1'b0;
		end
		else
		begin
			wr_commit_q <= end_data;
			if (end_data)
				wr_data_q <= tree_fill(cfg_width, side_on, rx_d);
		end
	end

	// ****************************************************************
	// error report
	// ****************************************************************
	// six-clock low pulse, retriggers
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			alert_cnt_q <= 3'd0;
			alert_oe_q  <= 1'b0;
			crc_err_q   <= 1'b0;
		end
		else
		begin
			crc_err_q <= bad;
			if (bad)
			begin
				alert_cnt_q <= `WCF_ALERT_PW;
				alert_oe_q  <= 1'b1;
			end
			else if (alert_cnt_q > 3'd1)
				alert_cnt_q <= alert_cnt_q - 3'd1;
			else
			begin
				alert_cnt_q <= 3'd0;
				alert_oe_q  <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			err_clear_q  <= 1'b0;
			err_status_q <= 1'b0;
		end
		else
		begin
			err_clear_q  <= bad | (err_clear_q & ~err_clr);
			err_status_q <= bad | (err_status_q & ~err_clr);
		end
	end

	assign link.alert_o  = 1'b0;
	assign link.alert_oe = alert_oe_q;
	assign wr_data       = wr_data_q;
	assign wr_commit     = wr_commit_q;
	assign crc_err       = crc_err_q;
	assign err_clear_bit = err_clear_q;
	assign err_status_bit = err_status_q;

endmodule : wcf_dev

// ---- wcf_link_properties.sv ----
/*
 * Concurrent checks on the write-data link between the two ends:
 * frame length, filler ones, idle lanes and alert pulse shape.
 * Assumes one clock domain and the interface signals as inputs.
 */
`timescale 1ns/1ps

module wcf_link_properties (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        wr_valid,
	input  wire logic [15:0] dq,
	input  wire logic [1:0]  dmi,
	input  wire logic        alert_o,
	input  wire logic        alert_oe
);

	// ****************************************************************
	// transfer index within the current frame
	// ****************************************************************
	logic [3:0] beat_q;
	logic [3:0] beat_d;

	// restarts at zero on every idle cycle between frames
	assign beat_d = wr_valid ? beat_q + 4'h1 : 4'h0;

	// short counter so long frames never need an unrolled repetition
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			beat_q <= 4'h0;
		else
			beat_q <= beat_d;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	chk_alert_pulse_width: assert property
		($rose(alert_oe) |-> alert_oe[*6] ##1 !alert_oe)
		else $error("alert pulse not six cycles");
	chk_alert_drive_low: assert property
		(alert_oe |-> !alert_o)
		else $error("alert driven high");
	chk_frame_length: assert property
		($rose(wr_valid) |-> wr_valid[*8] ##1
			(!wr_valid or (wr_valid[*2] ##1 !wr_valid)))
		else $error("frame length wrong");
	chk_idle_lanes_high: assert property
		(!wr_valid |-> dq == 16'hffff && dmi == 2'b11)
		else $error("lanes not high between frames");
	chk_last_beat_ones: assert property
		(wr_valid && beat_q == 4'd9 |-> dq[15:4] == 12'hfff && &dmi)
		else $error("transfer nine not filled with ones");
	chk_side_beat_ones: assert property
		(wr_valid && beat_q == 4'd8 |-> dmi == 2'b11)
		else $error("sideband not ones in transfer eight");
	// compare input registered one cycle, alert enable the next
	chk_alert_after_frame: assert property
		($rose(alert_oe) |-> $past(beat_q, 2) == 4'd9)
		else $error("alert without a finished checksum frame");
	chk_beat_in_range: assert property
		(wr_valid |-> beat_q <= 4'd9)
		else $error("frame longer than ten transfers");

endmodule : wcf_link_properties

// ---- tb_write_crc8_frame_check.sv ----
/*
 * Self-checking bench: drives the controller over Avalon-MM and
 * the device configuration, watches commits, checksums and flags.
 * Assumes the design files and the link checker are compiled first.
 */
`timescale 1ns/1ps

module tb_write_crc8_frame_check;
	import wcf_pkg::*;

	logic         clk;
	logic         rst;
	logic [4:0]   avs_address;
	logic         avs_read;
	logic         avs_write;
	logic [31:0]  avs_writedata;
	logic [31:0]  avs_readdata;
	logic         avs_waitrequest;
	wcf_width_t   cfg_width;
	logic         crc_en;
	logic         dm_en;
	logic         dbi_en;
	logic         err_clr;
	logic [143:0] wr_data;
	logic         wr_commit;
	logic         crc_err;
	logic         err_clear_bit;
	logic         err_status_bit;
	int           mismatches;
	int           checks_done;
	int           beat;
	int           flen;
	int           ncommit;
	int           nerr;
	logic [15:0]  cap8;
	logic [15:0]  cap9;
	logic [143:0] got;
	logic [31:0]  rd;

	wcf_link_if wcf_link_if_inst ();
	wcf_host wcf_host_inst (.clk(clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .link(wcf_link_if_inst));
	wcf_dev wcf_dev_inst (.clk(clk), .rst(rst), .cfg_width(cfg_width),
		.crc_en(crc_en), .dm_en(dm_en), .dbi_en(dbi_en), .err_clr(err_clr),
		.link(wcf_link_if_inst), .wr_data(wr_data), .wr_commit(wr_commit),
		.crc_err(crc_err), .err_clear_bit(err_clear_bit),
		.err_status_bit(err_status_bit));
	wcf_link_properties wcf_link_properties_inst (.clk(clk), .rst(rst),
		.wr_valid(wcf_link_if_inst.wr_valid), .dq(wcf_link_if_inst.dq),
		.dmi(wcf_link_if_inst.dmi), .alert_o(wcf_link_if_inst.alert_o),
		.alert_oe(wcf_link_if_inst.alert_oe));

	// 200 MHz core clock
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ****************************************************************
	// link monitor and shared tasks
	// ****************************************************************
	// records checksum transfers, frame length, commits and errors
	always @(posedge clk)
	begin
		if (wcf_link_if_inst.wr_valid === 1'b1)
		begin
			beat <= beat + 1;
			if (beat == 8)
				cap8 <= wcf_link_if_inst.dq;
			if (beat == 9)
				cap9 <= wcf_link_if_inst.dq;
		end
		else
		begin
			if (beat != 0)
				flen <= beat;
			beat <= 0;
		end
		if (wr_commit === 1'b1)
		begin
			got <= wr_data;
			ncommit <= ncommit + 1;
		end
		if (crc_err === 1'b1)
			nerr <= nerr + 1;
	end

	task automatic report_and_stop;
		if (mismatches == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [143:0] seen, input logic [143:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic timeout;
		mismatches++;
		$display("Error at %0t: wait ran out", $time);
		report_and_stop();
	endtask : timeout

	// one Avalon transfer; waitrequest sampled at each rising edge
	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		avs_address <= a;
		avs_read <= !wr;
		avs_write <= wr;
		avs_writedata <= d;
		for (n = 0; n < 20; n++)
		begin
			@(posedge clk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n == 20)
			timeout();
	endtask : bus

	// bit 71 shifted first from an all-zero state
	function automatic logic [7:0] crc72(input logic [71:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 71; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction : crc72

	// programs, sends and waits for one write frame, then compares
	task automatic frame(input logic [1:0] w, input logic crc,
		input logic dm, input logic dbi, input logic inj,
		input logic [143:0] raw);
		logic [143:0] t;
		logic [159:0] pad;
		logic [5:0]   ctl;
		logic         e;
		int           c0;
		int           e0;
		int           n;
		t = raw;
		pad = {16'h0000, raw};
		ctl = {inj, dbi, dm, crc, w};
		e = inj & crc;
		if (!dm && !dbi)
			t[143:136] = 8'hff;
		if (!dm && !dbi)
			t[71:64] = 8'hff;
		if (w == 2'b00)
			t[143:32] = {112{1'b1}};
		if (w == 2'b01)
			t[143:72] = {72{1'b1}};
		c0 = ncommit;
		e0 = nerr;
		cfg_width <= wcf_width_t'(w);
		crc_en <= crc;
		dm_en <= dm;
		dbi_en <= dbi;
		bus(1'b1, 5'h00, {26'h0, ctl});
		bus(1'b0, 5'h00, 32'h0);
		check(rd[5:0], ctl);
		for (n = 0; n < 5; n++)
			bus(1'b1, 5'(4 + 4 * n), pad[32 * n +: 32]);
		bus(1'b1, 5'h18, 32'h1);
		for (n = 0; n < 100; n++)
		begin
			bus(1'b0, 5'h1c, 32'h0);
			if (rd[0] === 1'b0)
				break;
		end
		if (n == 100)
			timeout();
		// busy may drop before the monitor has logged the last commit
		repeat (3) @(posedge clk);
		check(got, t);
		check(ncommit - c0, e ? 2 : 1);
		check(nerr - e0, e);
		check({rd[5:4], rd[2:1]}, {1'b0, e, 1'b0, e});
		check({err_status_bit, err_clear_bit}, {e, e});
		if (!crc)
			check(flen, 8);
		else
			check(flen, 10);
		if (crc && w == 2'b00)
			check({cap9[3:0], cap8[3:0]}, crc72(t[71:0]));
		if (crc && w != 2'b00)
			check(cap8[7:0], crc72(t[71:0]));
		if (crc && w == 2'b10)
			check(cap8[15:8], crc72(t[143:72]));
	endtask : frame

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial
	begin
		rst = 1'b1;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		cfg_width = WCF_X8;
		crc_en = 1'b0;
		dm_en = 1'b0;
		dbi_en = 1'b0;
		err_clr = 1'b0;
		mismatches = 0;
		checks_done = 0;
		beat = 0;
		flen = 0;
		ncommit = 0;
		nerr = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		bus(1'b0, 5'h1c, 32'h0);
		check(rd, 32'h0);
		bus(1'b0, 5'h18, 32'h0);
		check(rd, 32'h0);
		check(wcf_link_if_inst.alert_n, 1'b1);
		// no frame enables masking and inversion together
		frame(2'b01, 1'b1, 1'b0, 1'b0, 1'b0, {9{16'h3c96}});
		frame(2'b01, 1'b1, 1'b0, 1'b1, 1'b0, {9{16'h5a0f}});
		frame(2'b00, 1'b1, 1'b0, 1'b0, 1'b0, {9{16'hc3a5}});
		frame(2'b10, 1'b1, 1'b1, 1'b0, 1'b0, {9{16'h9e17}});
		frame(2'b10, 1'b1, 1'b0, 1'b0, 1'b0, {9{16'h0f1e}});
		frame(2'b01, 1'b0, 1'b0, 1'b0, 1'b1, {9{16'h4d8e}});
		// corrupted first attempt: retried, flags stay until cleared
		frame(2'b01, 1'b1, 1'b1, 1'b0, 1'b1, {9{16'h7b24}});
		@(posedge clk);
		err_clr <= 1'b1;
		@(posedge clk);
		err_clr <= 1'b0;
		repeat (2) @(posedge clk);
		check({err_status_bit, err_clear_bit}, 2'b00);
		bus(1'b1, 5'h1c, 32'h6);
		bus(1'b0, 5'h1c, 32'h0);
		check(rd[2:1], 2'b00);
		report_and_stop();
	end

endmodule : tb_write_crc8_frame_check
